// File: inc/gpio_jack_defs.vh
// Constants for the jack detect and wakeup pin port.
// Assumes an Avalon-MM slave with a 32-bit word per register.
`ifndef GPIO_JACK_DEFS_VH
`define GPIO_JACK_DEFS_VH
`define GJ_ADDR_W        12
`define GJ_OFF_DATA      12'h300
`define GJ_OFF_DIR       12'h304
`define GJ_OFF_MASK      12'h308
`define GJ_OFF_STAT      12'h30c
`define GJ_OFF_WAKE      12'h310
`define GJ_OFF_WSTAT     12'h314
`define GJ_NPIN          8
`define GJ_RST_DATA      8'h00
`define GJ_RST_DIR       8'h00
`define GJ_RST_MASK      8'h00
`define GJ_WK_PIN_LSB    0
`define GJ_WK_HW_EN      3
`define GJ_WK_SW_BIT     4
`define GJ_WK_SHORT      5
`define GJ_WK_ADVERT     6
`define GJ_DB_LONG_MS    16
`define GJ_DB_SHORT_MS   8
`define GJ_CLK_KHZ       250000
`define GJ_DB_LONG_CYC   (`GJ_DB_LONG_MS * `GJ_CLK_KHZ)
`define GJ_DB_SHORT_CYC  (`GJ_DB_SHORT_MS * `GJ_CLK_KHZ)
`define GJ_CNT_W         22
`endif

// File: rtl/gpio_jack_detect_wakeup.v
// Eight-pin general purpose port with debounced change interrupt and remote wakeup.
// Assumes one clock, synchronous reset, Avalon-MM register access and a USB core
// supplying suspend and the host's remote wakeup enable.
//
// Overview of operation
// RULE_01 - Each pin is input or output by its own direction bit.
// RULE_02 - An output pin drives the value held in the data register bit.
// RULE_03 - A level change on an input pin raises the change interrupt.
// RULE_04 - A per-pin mask bit decides whether that pin's change interrupt is forwarded.
// RULE_05 - Software reads the data register at 0x300 to see the pin levels (debounced for input pins).
// RULE_06 - Any pin may be chosen as the hardware wakeup input.
// RULE_07 - Rising edge on the wakeup pin during enabled suspend signals remote wakeup.
// RULE_08 - Wakeup only when host enabled it and the descriptor advertised it.
// RULE_09 - A software 0 to 1 write of the wakeup bit acts like a pin edge.
// RULE_10 - Change detection is debounced, with 16 ms or 8 ms selectable.
// RULE_11 - A change counts only after the level held steady the whole period.
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ns
`include "gpio_jack_defs.vh"
module gpio_jack_detect_wakeup #(
  parameter [`GJ_CNT_W-1:0] DB_LONG_CYC  = `GJ_DB_LONG_CYC,  // 16 ms in cycles
  parameter [`GJ_CNT_W-1:0] DB_SHORT_CYC = `GJ_DB_SHORT_CYC  // 8 ms in cycles
) (
  input  wire                 clk_sys,          // System clock, 250 MHz
  input  wire                 sys_rst,          // Synchronous reset, active high
  input  wire [`GJ_ADDR_W-1:0] avs_address,     // Byte address
  input  wire                 avs_read,         // Read request
  input  wire                 avs_write,        // Write request
  input  wire [31:0]          avs_writedata,    // Write data
  input  wire [3:0]           avs_byteenable,   // Byte enables
  output reg  [31:0]          avs_readdata,     // Read data
  output reg                  avs_waitrequest,  // Stall, low marks the answer
  input  wire [`GJ_NPIN-1:0]  pin_in,           // Pin levels from pads
  output reg  [`GJ_NPIN-1:0]  pin_out,          // Pin drive values
  output reg  [`GJ_NPIN-1:0]  pin_oe_n,         // Pad drive enable, low drives
  input  wire                 usb_suspended,    // Bus is suspended
  input  wire                 host_wake_en,     // Host set the remote wakeup feature
  output reg                  remote_wake,      // One-cycle wakeup request to USB core
  output reg                  irq               // Level interrupt
);

  // Register state
  reg [`GJ_NPIN-1:0] data_q;
  reg [`GJ_NPIN-1:0] dir_q;
  reg [`GJ_NPIN-1:0] mask_q;
  reg [`GJ_NPIN-1:0] stat_q;
  reg [6:0]          wake_q;
  reg                wstat_q;
  reg                wmask_q;
  reg                ack_q;

  // Pin synchronisers and debounce state
  reg [`GJ_NPIN-1:0] sync1_q;
  reg [`GJ_NPIN-1:0] sync2_q;
  reg [`GJ_NPIN-1:0] stable_q;
  reg [`GJ_CNT_W-1:0] db_cnt_q [0:`GJ_NPIN-1];
  reg [`GJ_NPIN-1:0] chg_d;
  reg                wk_prev_q;

  // Byte-lane merge of a write into an 8-bit register
  function [7:0] lane_merge;
    input [7:0]  old_v;
    input [31:0] wd;
    input [3:0]  be;
    begin
      lane_merge = be[0] ? wd[7:0] : old_v;
    end
  endfunction

  // Address compare used by both read and write decoding
  function hit;
    input [`GJ_ADDR_W-1:0] a;
    input [`GJ_ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  wire access   = (avs_read | avs_write) & ~ack_q;
  wire wr_take  = avs_write & ack_q;
  wire rd_take  = avs_read & ack_q;
  wire [`GJ_CNT_W-1:0] db_limit = wake_q[`GJ_WK_SHORT] ? DB_SHORT_CYC : DB_LONG_CYC; // RULE_10
  wire [2:0] wk_sel = wake_q[`GJ_WK_PIN_LSB+2:`GJ_WK_PIN_LSB];
  wire       wk_lvl = stable_q[wk_sel] | wake_q[`GJ_WK_SW_BIT]; // RULE_06 RULE_09
  wire       wk_en  = usb_suspended & host_wake_en & wake_q[`GJ_WK_ADVERT]; // RULE_08
  wire       wk_fire = wk_en & wake_q[`GJ_WK_HW_EN] & wk_lvl & ~wk_prev_q; // RULE_07

  // Two-flop pin synchroniser
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Per-pin debounce: new level must stay for the full period
  genvar g;
  generate
    for (g = 0; g < `GJ_NPIN; g = g + 1) begin : db
      always @(posedge clk_sys) begin
        if (sys_rst) begin
          db_cnt_q[g]  <= {`GJ_CNT_W{1'b0}};
          stable_q[g]  <= 1'b0;
        end else if (sync2_q[g] == stable_q[g]) begin
          db_cnt_q[g]  <= {`GJ_CNT_W{1'b0}}; // RULE_11
        end else if (db_cnt_q[g] >= db_limit - 1'b1) begin
          db_cnt_q[g]  <= {`GJ_CNT_W{1'b0}};
          stable_q[g]  <= sync2_q[g]; // RULE_10
        end else begin
          db_cnt_q[g]  <= db_cnt_q[g] + 1'b1;
        end
      end
      // Change of either direction on an input pin
      always @* begin
        chg_d[g] = ~dir_q[g] & (db_cnt_q[g] >= db_limit - 1'b1) & (sync2_q[g] != stable_q[g]); // RULE_03
      end
    end
  endgenerate

  // Bus handshake: one wait cycle per access
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_q           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_q           <= access;
      avs_waitrequest <= ~access;
    end
  end

  // Software writable registers
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      data_q <= `GJ_RST_DATA;
      dir_q  <= `GJ_RST_DIR;
      mask_q <= `GJ_RST_MASK;
      wake_q <= 7'h00;
      wmask_q <= 1'b0;
    end else if (wr_take) begin
      if (hit(avs_address, `GJ_OFF_DATA)) data_q <= lane_merge(data_q, avs_writedata, avs_byteenable); // RULE_02
      if (hit(avs_address, `GJ_OFF_DIR))  dir_q  <= lane_merge(dir_q, avs_writedata, avs_byteenable); // RULE_01
      if (hit(avs_address, `GJ_OFF_MASK)) mask_q <= lane_merge(mask_q, avs_writedata, avs_byteenable); // RULE_04
      if (hit(avs_address, `GJ_OFF_WAKE) && avs_byteenable[0]) wake_q <= avs_writedata[6:0];
      if (hit(avs_address, `GJ_OFF_WAKE) && avs_byteenable[1]) wmask_q <= avs_writedata[8];
    end
  end

  // Sticky status: a read clears only the bits it returned, so an event that
  // lands between the data capture and the read's answer is not lost
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      stat_q    <= 8'h00;
      wstat_q   <= 1'b0;
      wk_prev_q <= 1'b0;
    end else begin
      wk_prev_q <= wk_lvl;
      stat_q    <= (stat_q & ~((rd_take && hit(avs_address, `GJ_OFF_STAT)) ? avs_readdata[7:0] : 8'h00))
                   | chg_d; // RULE_03
      wstat_q   <= (wstat_q & ~(rd_take && hit(avs_address, `GJ_OFF_WSTAT) && avs_readdata[0])) | wk_fire;
    end
  end

  // Read data mux; unmapped reads return zero
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & access) begin
      if (hit(avs_address, `GJ_OFF_DATA))
        avs_readdata <= {24'h000000, (dir_q & data_q) | (~dir_q & stable_q)}; // RULE_05
      else if (hit(avs_address, `GJ_OFF_DIR))
        avs_readdata <= {24'h000000, dir_q};
      else if (hit(avs_address, `GJ_OFF_MASK))
        avs_readdata <= {24'h000000, mask_q};
      else if (hit(avs_address, `GJ_OFF_STAT))
        avs_readdata <= {24'h000000, stat_q};
      else if (hit(avs_address, `GJ_OFF_WAKE))
        avs_readdata <= {23'h000000, wmask_q, 1'b0, wake_q};
      else if (hit(avs_address, `GJ_OFF_WSTAT))
        avs_readdata <= {31'h00000000, wstat_q};
      else
        avs_readdata <= 32'h00000000;
    end
  end

  // Pins, wakeup pulse and interrupt
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_out     <= 8'h00;
      pin_oe_n    <= 8'hff;
      remote_wake <= 1'b0;
      irq         <= 1'b0;
    end else begin
      pin_out     <= data_q; // RULE_02
      pin_oe_n    <= ~dir_q; // RULE_01
      remote_wake <= wk_fire; // RULE_07
      irq         <= |(stat_q & mask_q) | (wstat_q & wmask_q); // RULE_04
    end
  end

endmodule

// File: tb/gpio_jack_partner.sv
// Far side: jack switches on the pins and a USB host that resumes on wakeup.
// Assumes the bench sets jack levels and the suspend request after clk_sys edges.
`timescale 1ns/1ns
module gpio_jack_partner (
  input  wire       clk_sys,       // System clock
  input  wire [7:0] jack,          // Switch levels
  input  wire       sus_req,       // Host wants the bus suspended
  input  wire [7:0] pin_out,       // Drive values
  input  wire [7:0] pin_oe_n,      // Drive enables, low drives
  input  wire       remote_wake,   // Wakeup pulse
  output wire [7:0] pin_in,        // Pad levels
  output reg        usb_suspended  // Host suspend state
);
  // Driven pins read back their own drive, others follow the switch
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & jack);
  // Host resumes on a wakeup pulse
  always @(posedge clk_sys) begin
    usb_suspended <= remote_wake ? 1'b0 : sus_req;
  end
endmodule

// File: tb/gpio_jack_detect_wakeup_assertions.sv
// Checker on the ports of the pin port.
// Assumes it is bound into the port with matching port names.
`timescale 1ns/1ns
`include "gpio_jack_defs.vh"
module gpio_jack_detect_wakeup_assertions (
  input wire        clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest, // Clock, reset, bus
  input wire        usb_suspended, host_wake_en, remote_wake, irq,            // Wake, interrupt
  input wire [11:0] avs_address,                                              // Address
  input wire [31:0] avs_writedata, avs_readdata,                              // Data
  input wire [3:0]  avs_byteenable,                                           // Lanes
  input wire [7:0]  pin_in, pin_out, pin_oe_n                                 // Pins
);
  reg [7:0] msk_q;
  reg [8:0] wk_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Shadow of mask and wakeup settings
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      msk_q <= 8'h00;
      wk_q <= 9'h000;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == `GJ_OFF_MASK) msk_q <= avs_writedata[7:0];
      if (avs_address == `GJ_OFF_WAKE) wk_q <= avs_writedata[8:0];
    end
  end
  sequence s_wr(off);
    avs_write && !avs_waitrequest && avs_address == off;
  endsequence
  property p_dir; s_wr(`GJ_OFF_DIR) |-> ##2 pin_oe_n == ~$past(avs_writedata[7:0], 2); endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");
  property p_data; s_wr(`GJ_OFF_DATA) |-> ##2 pin_out == $past(avs_writedata[7:0], 2); endproperty
  a_data: assert property (p_data) else $error("pin data not driven");
  property p_ack; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("answer late");
  property p_irq; irq |-> $past(msk_q) != 8'h00 || $past(wk_q[8]); endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
  property p_pulse; remote_wake |=> !remote_wake; endproperty
  a_pulse: assert property (p_pulse) else $error("wakeup pulse too long");
  property p_cond; remote_wake |-> $past(usb_suspended) && $past(host_wake_en); endproperty
  a_cond: assert property (p_cond) else $error("wakeup without host enable");
  property p_wen; remote_wake |-> wk_q[3] && wk_q[6]; endproperty
  a_wen: assert property (p_wen) else $error("wakeup not configured");
  property p_unmap;
    avs_read && !avs_waitrequest && (avs_address < `GJ_OFF_DATA || avs_address > `GJ_OFF_WSTAT) |-> avs_readdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule

// File: tb/gpio_jack_detect_wakeup_tb_top.sv
// Bench for the pin port: bus tasks, jack stimulus, queued read checks.
// Assumes the port, partner model and checker are compiled alongside.
`timescale 1ns/1ns
`include "gpio_jack_defs.vh"
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin n_mismatch++; $display("unexpected %0t: %h", $time, a); end end
module gpio_jack_detect_wakeup_tb_top;
  reg        clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, host_wake_en = 0, sus_req = 0;
  reg [11:0] avs_address = 0;
  reg [31:0] avs_writedata = 0, x, r;
  reg [7:0]  jack = 0;
  wire [31:0] avs_readdata;
  wire [7:0] pin_in, pin_out, pin_oe_n;
  wire       avs_waitrequest, usb_suspended, remote_wake, irq;
  integer    n_mismatch = 0, num_checks = 0, seed = 99470, n, i;
  reg [31:0] q[$];
  gpio_jack_detect_wakeup #(.DB_LONG_CYC(22'h10), .DB_SHORT_CYC(22'h8)) dut_u (.*, .avs_byteenable(4'hf));
  gpio_jack_partner far_u (.*);
  initial forever #2 clk_sys = ~clk_sys;
  // Oldest note against each read answer, taken at the edge that ends the wait
  always @(posedge clk_sys) if (avs_read && avs_waitrequest === 1'b0) begin
    x = q.pop_front();
    if (^x !== 1'bx) `CHK(avs_readdata, x)
  end
  task bus(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      if (!w) q.push_back(d);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #40000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    bus(0, `GJ_OFF_DIR, {24'h0, `GJ_RST_DIR});
    bus(0, `GJ_OFF_MASK, {24'h0, `GJ_RST_MASK});
    bus(0, `GJ_OFF_DATA, {24'h0, `GJ_RST_DATA});
    bus(0, 12'h3fc, 32'h0);
    $display("test reset done");
    for (n = 0; n < 4; n++) begin
      r = $random(seed);
      bus(1, `GJ_OFF_DIR, {24'h0, r[15:8]});
      bus(1, `GJ_OFF_DATA, {24'h0, r[7:0]});
      repeat (2) @(negedge clk_sys);
      `CHK(pin_oe_n, ~r[15:8])
      `CHK(pin_out, r[7:0])
    end
    bus(1, `GJ_OFF_DIR, 32'h0);
    repeat (40) @(posedge clk_sys);
    bus(0, `GJ_OFF_STAT, 32'hx);
    $display("test outputs done");
    bus(1, `GJ_OFF_MASK, 32'h11);
    jack <= 8'h02;
    repeat (40) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    @(posedge clk_sys);
    jack <= 8'h03;
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(negedge clk_sys);
    `CHK(irq, 1'b1)
    bus(0, `GJ_OFF_STAT, 32'h03);
    repeat (2) @(negedge clk_sys);
    `CHK(irq, 1'b0)
    @(posedge clk_sys);
    jack <= 8'h07;
    repeat (4) @(posedge clk_sys);
    jack <= 8'h03;
    repeat (30) @(posedge clk_sys);
    bus(0, `GJ_OFF_STAT, 32'h0);
    bus(0, `GJ_OFF_DATA, 32'h03);
    for (r = 0; r < 2; r++) begin
      if (r == 1) bus(1, `GJ_OFF_WAKE, 32'h20);
      @(posedge clk_sys);
      jack <= jack ^ 8'h10;
      for (n = 0; n < 40 && irq !== 1'b1; n++) @(negedge clk_sys);
      `CHK(r == 0 ? n >= 16 && n <= 24 : n >= 8 && n < 16, 1'b1)
      bus(0, `GJ_OFF_STAT, 32'h10);
    end
    $display("test change done");
    host_wake_en <= 1'b1;
    sus_req <= 1'b1;
    for (r = 0; r < 3; r++) begin
      bus(1, `GJ_OFF_WAKE, r == 1 ? 32'h0f : r == 0 ? 32'h4f : 32'h4b);
      if (r < 2) bus(1, `GJ_OFF_WAKE, r == 1 ? 32'h1f : 32'h5f);
      else jack <= 8'h0b;
      for (n = 0; n < 40 && remote_wake !== 1'b1; n++) @(negedge clk_sys);
      `CHK(remote_wake, r != 1)
    end
    $display("test wakeup done");
    tally_and_finish;
  end
endmodule
bind gpio_jack_detect_wakeup gpio_jack_detect_wakeup_assertions chk_u (.*);
